/* hw/cctx_pkg.sv */
package cctx_pkg;

    // ------------------------------------------------------------
    // table geometry
    // ------------------------------------------------------------
    localparam int NUM_ENTRIES = 5;
    localparam int HANDLE_W = 3;
    localparam int ID_W = 29;
    localparam int LEN_W = 4;
    localparam int PERIOD_W = 16;
    localparam logic [LEN_W-1:0] MAX_LEN = 4'h8;
    localparam logic [PERIOD_W-1:0] MIN_PERIOD = 16'h0005;
    localparam logic [HANDLE_W-1:0] NO_HANDLE = 3'h7;
    localparam logic [7:0] VALID_PORT = 8'h01;

    // ------------------------------------------------------------
    // time base: one period unit is 0.1 ms
    // ------------------------------------------------------------
    localparam int UNIT_NS = 100000;
    localparam int CLK_NS = 8;
    localparam int TICK_CYCLES_DEF = (UNIT_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam logic [7:0] OFF_STG_ID = 8'h0C;
    localparam logic [7:0] OFF_STG_LEN = 8'h10;
    localparam logic [7:0] OFF_STG_DLO = 8'h14;
    localparam logic [7:0] OFF_STG_DHI = 8'h18;
    localparam logic [7:0] OFF_REG_ACC = 8'h1C;
    localparam logic [7:0] OFF_REG_RD = 8'h20;
    localparam logic [7:0] OFF_IRQ_ST = 8'h24;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h28;
    localparam logic [7:0] OFF_TABLE = 8'h2C;
    localparam logic [7:0] OFF_PORT = 8'h30;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_HANDLE_LSB = 4;
    localparam int RES_FAIL_BIT = 4;
    localparam int RES_PORT_BIT = 5;
    localparam int STG_EXT_BIT = 29;
    localparam int STG_RTR_BIT = 30;
    localparam int STG_PERIOD_LSB = 16;
    localparam int RA_VAL_LSB = 16;
    localparam int RA_READ_BIT = 24;
    localparam int ST_BUF_FULL_BIT = 8;
    localparam int TBL_EN_LSB = 8;

    // interrupt event bits
    localparam int IRQ_W = 5;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_SENT = 2;
    localparam int IRQ_PORT = 3;
    localparam int IRQ_RDDONE = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_ADD = 3'h1,
        OP_REMOVE = 3'h2,
        OP_START = 3'h3,
        OP_STOP = 3'h4,
        OP_FLUSH = 3'h5
    } cctx_op_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_READ = 3'b010,
        S_SEND = 3'b100
    } cctx_state_e;

    // packed so that bus_off lands in bit 7 and rx_avail in bit 0
    typedef struct packed {
        logic bus_off;
        logic error;
        logic tx_busy;
        logic rx_busy;
        logic tx_done;
        logic tx_buf_free;
        logic overrun;
        logic rx_avail;
    } cctx_status_s;

    typedef struct packed {
        logic ext;
        logic rtr;
        logic [LEN_W-1:0] len;
        logic [ID_W-1:0] id;
        logic [63:0] data;
    } cctx_frame_s;

endpackage

/* hw/cctx_entry_mem.sv */
`timescale 1ns/100ps
module cctx_entry_mem
    import cctx_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input wire logic wr_en,
    input wire logic [HANDLE_W-1:0] wr_addr,
    input cctx_pkg::cctx_frame_s wr_data,
    // read port, data one cycle after rd_en
    input wire logic rd_en,
    input wire logic [HANDLE_W-1:0] rd_addr,
    output cctx_pkg::cctx_frame_s rd_data
);
    cctx_frame_s mem [NUM_ENTRIES];
    cctx_frame_s rd_data_r;

    // ------------------------------------------------------------
    // storage, no reset: contents only matter once a slot is valid
    // ------------------------------------------------------------
    always_ff @(posedge pclk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // registered read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_data_r <= '0;
        else if (rd_en)
            rd_data_r <= mem[rd_addr];
    end

    assign rd_data = rd_data_r;
endmodule

/* hw/cctx_top.sv */
// What this block does
// - bits 7..4 report bus-off, error, transmit, receive
// - bits 3..0 report done, buffer free, overrun, data
// - table holds at most five periodic entries
// - add returns handle; lower handle wins priority
// - entry format bit selects standard or extended id
// - entry remote flag sends remote frame, else data
// - period counted in 0.1 ms, minimum five
// - add with full table fails, no handle
// - started entry sends once every period
// - stopped entry keeps its stored contents
// - removed entry frees its slot
// - byte write forwarded to controller register unchanged
// - byte read returns controller register value
// - flush request empties on-board message buffer
// - only port 1; others give port error
`timescale 1ns/100ps
module cctx_top
    import cctx_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // controller side
    input cctx_pkg::cctx_status_s ctl_status,
    input wire logic message_buffer_full,
    output logic [15:0] ctl_addr,
    output logic [7:0] ctl_wdata,
    output logic ctl_wr,
    output logic ctl_rd,
    input wire logic [7:0] ctl_rdata,
    output logic flush_message_buffer,
    // periodic frame output
    output logic tx_valid,
    output cctx_pkg::cctx_frame_s tx_frame,
    input wire logic tx_ready,
    // interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lowest set bit, used for free slot search and due selection
    function automatic logic [HANDLE_W-1:0] lowest_set(input logic [NUM_ENTRIES-1:0] v);
        logic [HANDLE_W-1:0] r;
        r = NO_HANDLE;
        for (int i = NUM_ENTRIES - 1; i >= 0; i--)
            if (v[i])
                r = HANDLE_W'(i);
        return r;
    endfunction

    function automatic logic is_reg(input logic [11:0] a, input logic [7:0] off);
        return (a[11:8] == 4'h0) && (a[7:0] == off);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic [2:0] cmd_op_r;
    logic [HANDLE_W-1:0] cmd_handle_r;
    logic cmd_go_r;
    logic [HANDLE_W-1:0] res_handle_r;
    logic res_fail_r, res_port_r;
    logic [31:0] stg_id_r, stg_len_r, stg_dlo_r, stg_dhi_r;
    logic [7:0] port_r;
    logic [15:0] ctl_addr_r;
    logic [7:0] ctl_wdata_r, reg_rd_r;
    logic ctl_wr_r, ctl_rd_r, rd_wait_r, flush_r;
    logic [IRQ_W-1:0] irq_st_r, irq_msk_r, irq_ev;
    logic irq_r;
    logic [NUM_ENTRIES-1:0] valid_r, en_r, pend_r, due, pend_clr;
    logic [PERIOD_W-1:0] period_r [NUM_ENTRIES];
    logic [PERIOD_W-1:0] cnt_r [NUM_ENTRIES];
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
    logic tick;
    cctx_state_e state_r;
    logic tx_valid_r;
    cctx_frame_s tx_frame_r, mem_rd, mem_wr;
    logic mem_we, mem_re, sent;

    logic setup, wr_acc, rd_acc, mapped, port_ok, cmd_ok;
    logic [HANDLE_W-1:0] free_slot, due_sel;
    logic [NUM_ENTRIES-1:0] h_onehot;
    logic [PERIOD_W-1:0] stg_period;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pready_r;
    assign rd_acc = setup && !pwrite;
    assign port_ok = (port_r == VALID_PORT);
    assign free_slot = lowest_set(~valid_r);
    assign due_sel = lowest_set(pend_r);
    assign h_onehot = NUM_ENTRIES'(1) << cmd_handle_r;
    assign stg_period = stg_len_r[STG_PERIOD_LSB +: PERIOD_W];

    // ------------------------------------------------------------
    // apb slave: answer registered in setup, ready in first access
    // ------------------------------------------------------------
    always_comb
    begin
        mapped = 1'b1;
        if (is_reg(paddr, OFF_STATUS)) ;
        else if (is_reg(paddr, OFF_CMD)) ;
        else if (is_reg(paddr, OFF_RESULT)) ;
        else if (is_reg(paddr, OFF_STG_ID)) ;
        else if (is_reg(paddr, OFF_STG_LEN)) ;
        else if (is_reg(paddr, OFF_STG_DLO)) ;
        else if (is_reg(paddr, OFF_STG_DHI)) ;
        else if (is_reg(paddr, OFF_REG_ACC)) ;
        else if (is_reg(paddr, OFF_REG_RD)) ;
        else if (is_reg(paddr, OFF_IRQ_ST)) ;
        else if (is_reg(paddr, OFF_IRQ_MSK)) ;
        else if (is_reg(paddr, OFF_TABLE)) ;
        else if (is_reg(paddr, OFF_PORT)) ;
        else
            mapped = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
        end
    end

    // read mux; status byte comes straight from the controller
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= '0;
        else if (rd_acc)
        begin
            prdata_r <= '0;
            if (is_reg(paddr, OFF_STATUS))
            begin
                prdata_r[7:0] <= ctl_status;
                prdata_r[ST_BUF_FULL_BIT] <= message_buffer_full;
            end
            else if (is_reg(paddr, OFF_CMD))
            begin
                prdata_r[CMD_OP_LSB +: 3] <= cmd_op_r;
                prdata_r[CMD_HANDLE_LSB +: HANDLE_W] <= cmd_handle_r;
            end
            else if (is_reg(paddr, OFF_RESULT))
            begin
                prdata_r[HANDLE_W-1:0] <= res_handle_r;
                prdata_r[RES_FAIL_BIT] <= res_fail_r;
                prdata_r[RES_PORT_BIT] <= res_port_r;
            end
            else if (is_reg(paddr, OFF_STG_ID))
                prdata_r <= stg_id_r;
            else if (is_reg(paddr, OFF_STG_LEN))
                prdata_r <= stg_len_r;
            else if (is_reg(paddr, OFF_STG_DLO))
                prdata_r <= stg_dlo_r;
            else if (is_reg(paddr, OFF_STG_DHI))
                prdata_r <= stg_dhi_r;
            else if (is_reg(paddr, OFF_REG_ACC))
            begin
                prdata_r[15:0] <= ctl_addr_r;
                prdata_r[RA_VAL_LSB +: 8] <= ctl_wdata_r;
            end
            else if (is_reg(paddr, OFF_REG_RD))
                prdata_r[7:0] <= reg_rd_r;
            else if (is_reg(paddr, OFF_IRQ_ST))
                prdata_r[IRQ_W-1:0] <= irq_st_r;
            else if (is_reg(paddr, OFF_IRQ_MSK))
                prdata_r[IRQ_W-1:0] <= irq_msk_r;
            else if (is_reg(paddr, OFF_TABLE))
            begin
                prdata_r[NUM_ENTRIES-1:0] <= valid_r;
                prdata_r[TBL_EN_LSB +: NUM_ENTRIES] <= en_r;
            end
            else if (is_reg(paddr, OFF_PORT))
                prdata_r[7:0] <= port_r;
        end
    end

    // ------------------------------------------------------------
    // staging, port and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stg_id_r <= '0;
            stg_len_r <= '0;
            stg_dlo_r <= '0;
            stg_dhi_r <= '0;
            port_r <= VALID_PORT;
            irq_msk_r <= '0;
        end
        else if (wr_acc)
        begin
            if (is_reg(paddr, OFF_STG_ID))
                stg_id_r <= pwdata;
            if (is_reg(paddr, OFF_STG_LEN))
                stg_len_r <= pwdata;
            if (is_reg(paddr, OFF_STG_DLO))
                stg_dlo_r <= pwdata;
            if (is_reg(paddr, OFF_STG_DHI))
                stg_dhi_r <= pwdata;
            if (is_reg(paddr, OFF_PORT))
                port_r <= pwdata[7:0];
            if (is_reg(paddr, OFF_IRQ_MSK))
                irq_msk_r <= pwdata[IRQ_W-1:0];
        end
    end

    // command capture; executed on the following edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_op_r <= OP_NOP;
            cmd_handle_r <= '0;
            cmd_go_r <= 1'b0;
        end
        else
        begin
            cmd_go_r <= wr_acc && is_reg(paddr, OFF_CMD);
            if (wr_acc && is_reg(paddr, OFF_CMD))
            begin
                cmd_op_r <= pwdata[CMD_OP_LSB +: 3];
                cmd_handle_r <= pwdata[CMD_HANDLE_LSB +: HANDLE_W];
            end
        end
    end

    // ------------------------------------------------------------
    // controller register pass-through
    // ------------------------------------------------------------
    // a write to the access register strobes the controller once;
    // nothing is strobed when the selected port is wrong
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_addr_r <= '0;
            ctl_wdata_r <= '0;
            ctl_wr_r <= 1'b0;
            ctl_rd_r <= 1'b0;
            rd_wait_r <= 1'b0;
            reg_rd_r <= '0;
        end
        else
        begin
            ctl_wr_r <= 1'b0;
            ctl_rd_r <= 1'b0;
            rd_wait_r <= ctl_rd_r;
            if (wr_acc && is_reg(paddr, OFF_REG_ACC) && port_ok)
            begin
                ctl_addr_r <= pwdata[15:0];
                ctl_wdata_r <= pwdata[RA_VAL_LSB +: 8];
                ctl_wr_r <= !pwdata[RA_READ_BIT];
                ctl_rd_r <= pwdata[RA_READ_BIT];
            end
            if (ctl_rd_r)
                reg_rd_r <= ctl_rdata;
        end
    end

    // ------------------------------------------------------------
    // command execution and result
    // ------------------------------------------------------------
    assign cmd_ok = port_ok && (((cmd_op_r == OP_ADD) && !(&valid_r) && (stg_len_r[LEN_W-1:0] <= MAX_LEN)
                    && (stg_period >= MIN_PERIOD))
                    || (((cmd_op_r == OP_REMOVE) || (cmd_op_r == OP_START) || (cmd_op_r == OP_STOP))
                    && (cmd_handle_r < HANDLE_W'(NUM_ENTRIES)) && valid_r[cmd_handle_r])
                    || (cmd_op_r == OP_FLUSH));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_handle_r <= NO_HANDLE;
            res_fail_r <= 1'b0;
            res_port_r <= 1'b0;
            flush_r <= 1'b0;
        end
        else
        begin
            flush_r <= cmd_go_r && cmd_ok && (cmd_op_r == OP_FLUSH);
            if (cmd_go_r)
            begin
                res_fail_r <= !cmd_ok;
                res_port_r <= !port_ok;
                if (cmd_op_r == OP_ADD)
                    res_handle_r <= cmd_ok ? free_slot : NO_HANDLE;
                else
                    res_handle_r <= cmd_handle_r;
            end
        end
    end

    // stored frame built from staging; length kept as given
    always_comb
    begin
        mem_wr.ext = stg_id_r[STG_EXT_BIT];
        mem_wr.rtr = stg_id_r[STG_RTR_BIT];
        mem_wr.len = stg_len_r[LEN_W-1:0];
        mem_wr.id = stg_id_r[STG_EXT_BIT] ? stg_id_r[ID_W-1:0] : {18'h00000, stg_id_r[10:0]};
        mem_wr.data = {stg_dhi_r, stg_dlo_r};
    end
    assign mem_we = cmd_go_r && cmd_ok && (cmd_op_r == OP_ADD);

    // ------------------------------------------------------------
    // table flags and period time base
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid_r <= '0;
            en_r <= '0;
        end
        else if (cmd_go_r && cmd_ok)
        begin
            case (cmd_op_r)
                OP_ADD: valid_r[free_slot] <= 1'b1;
                OP_REMOVE:
                begin
                    valid_r <= valid_r & ~h_onehot;
                    en_r <= en_r & ~h_onehot;
                end
                OP_START: en_r <= en_r | h_onehot;
                OP_STOP: en_r <= en_r & ~h_onehot;
                default: ;
            endcase
        end
    end

    // 0.1 ms tick shared by all entries
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_r <= '0;
        else if (tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
    end
    assign tick = (tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

    // per-entry countdown, reloaded on start and on expiry
    for (genvar g = 0; g < NUM_ENTRIES; g++)
    begin : g_entry
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                period_r[g] <= '0;
                cnt_r[g] <= '0;
            end
            else
            begin
                if (mem_we && (free_slot == HANDLE_W'(g)))
                    period_r[g] <= stg_period;
                if (cmd_go_r && cmd_ok && (cmd_op_r == OP_START) && h_onehot[g])
                    cnt_r[g] <= period_r[g];
                else if (tick && en_r[g])
                    cnt_r[g] <= due[g] ? period_r[g] : cnt_r[g] - 1'b1;
            end
        end
        assign due[g] = tick && en_r[g] && (cnt_r[g] <= 16'h0001);
    end

    // pending clears: the entry just fetched, stopped or removed entries
    always_comb
    begin
        pend_clr = '0;
        if (mem_re)
            pend_clr[due_sel] = 1'b1;
        if (cmd_go_r && cmd_ok && ((cmd_op_r == OP_STOP) || (cmd_op_r == OP_REMOVE)))
            pend_clr = pend_clr | h_onehot;
    end

    // pending: expiry wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_r <= '0;
        else
            pend_r <= (pend_r & ~pend_clr) | due;
    end

    // ------------------------------------------------------------
    // transmit sequencer: one frame at a time, lowest handle first
    // ------------------------------------------------------------
    assign mem_re = (state_r == S_IDLE) && (|pend_r);
    assign sent = (state_r == S_SEND) && tx_ready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= S_IDLE;
            tx_valid_r <= 1'b0;
            tx_frame_r <= '0;
        end
        else
        begin
            case (state_r)
                S_IDLE:
                    if (|pend_r)
                        state_r <= S_READ;
                S_READ:
                begin
                    tx_frame_r <= mem_rd;
                    tx_valid_r <= 1'b1;
                    state_r <= S_SEND;
                end
                S_SEND:
                    if (tx_ready)
                    begin
                        tx_valid_r <= 1'b0;
                        state_r <= S_IDLE;
                    end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    cctx_entry_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mem_we),
        .wr_addr(free_slot),
        .wr_data(mem_wr),
        .rd_en(mem_re),
        .rd_addr(due_sel),
        .rd_data(mem_rd)
    );

    // ------------------------------------------------------------
    // interrupts: sticky, write one to clear, set wins
    // ------------------------------------------------------------
    always_comb
    begin
        irq_ev = '0;
        irq_ev[IRQ_DONE] = cmd_go_r && cmd_ok;
        irq_ev[IRQ_FAIL] = cmd_go_r && !cmd_ok;
        irq_ev[IRQ_SENT] = sent;
        irq_ev[IRQ_PORT] = (cmd_go_r || (wr_acc && is_reg(paddr, OFF_REG_ACC))) && !port_ok;
        irq_ev[IRQ_RDDONE] = rd_wait_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_st_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            if (wr_acc && is_reg(paddr, OFF_IRQ_ST))
                irq_st_r <= (irq_st_r & ~pwdata[IRQ_W-1:0]) | irq_ev;
            else
                irq_st_r <= irq_st_r | irq_ev;
            irq_r <= |(irq_st_r & irq_msk_r);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign ctl_addr = ctl_addr_r;
    assign ctl_wdata = ctl_wdata_r;
    assign ctl_wr = ctl_wr_r;
    assign ctl_rd = ctl_rd_r;
    assign flush_message_buffer = flush_r;
    assign tx_valid = tx_valid_r;
    assign tx_frame = tx_frame_r;
    assign irq = irq_r;
endmodule

/* tb/cctx_top_props.sv */
`timescale 1ns/100ps
module cctx_top_props
    import cctx_pkg::*;
(
    // watched ports
    input wire logic pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic ctl_wr, ctl_rd, tx_valid, tx_ready,
    input wire logic [15:0] ctl_addr,
    input wire logic [7:0] ctl_wdata,
    input cctx_pkg::cctx_frame_s tx_frame
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready) else $error("ready held too long");
    AST_WR_FWD: assert property (ctl_wr |-> $past(psel && penable && pwrite && paddr == 12'h01C)
        && ctl_wdata == $past(pwdata[23:16]) && ctl_addr == $past(pwdata[15:0])) else $error("byte write altered");
    AST_RD_FWD: assert property (ctl_rd |-> $past(pwdata[24] && psel && penable) && ctl_addr ==
        $past(pwdata[15:0])) else $error("byte read offset wrong");
    AST_WR_PULSE: assert property (ctl_wr |=> !ctl_wr) else $error("write strobe stuck");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
        else $error("frame dropped before accept");
    AST_STD_ID: assert property (tx_valid && !tx_frame.ext |-> tx_frame.id[28:11] == 18'h0)
        else $error("standard id too wide");
    AST_LEN: assert property (tx_valid |-> tx_frame.len <= 4'h8) else $error("length above eight");
    AST_ONE_AT_A_TIME: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("no gap");
endmodule
bind cctx_top cctx_top_props i_props (.*);

/* tb/cctx_ctl_model.sv */
`timescale 1ns/100ps
module cctx_ctl_model
(
    // controller and transmitter side
    input wire logic pclk, ctl_wr, ctl_rd, tx_valid, slow,
    input wire logic [15:0] ctl_addr,
    input wire logic [7:0] ctl_wdata,
    output logic [7:0] ctl_rdata,
    output logic tx_ready
);
    logic [7:0] mem_r [0:255];
    logic [1:0] wait_r;
    // controller byte registers
    always_ff @(posedge pclk)
        if (ctl_wr)
            mem_r[ctl_addr[7:0]] <= ctl_wdata;
    // idle bus shows the inverse so stale data cannot pass
    assign ctl_rdata = ctl_rd ? mem_r[ctl_addr[7:0]] : ~mem_r[ctl_addr[7:0]];
    // transmitter accepts at once or after a stall
    always_ff @(posedge pclk)
    begin
        wait_r <= (tx_valid && !tx_ready) ? wait_r + 2'h1 : 2'h0;
        tx_ready <= tx_valid && !tx_ready && (!slow || wait_r == 2'h2);
    end
endmodule

/* tb/cctx_top_tb.sv */
`timescale 1ns/100ps
module cctx_top_tb;
    import cctx_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, se;
    logic message_buffer_full = 1'b0, pready, pslverr, ctl_wr, ctl_rd, flush_message_buffer, tx_valid, tx_ready, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] ctl_addr;
    logic [7:0] ctl_wdata, ctl_rdata;
    cctx_status_s ctl_status = 8'h00;
    cctx_frame_s tx_frame, sent[$];
    cctx_frame_s f0 = {1'b0, 1'b1, 4'h8, 29'h600, 64'h0706050403020100};
    cctx_frame_s f1 = {1'b1, 1'b0, 4'h8, 29'h1ABCDE01, 64'h0706050403020100};
    int errors = 0, n_compared = 0, flushes = 0, k, t_sent[$];
    cctx_top #(.TICK_CYCLES(10)) i_dut (.*);
    cctx_ctl_model i_ctl (.*);
    initial forever #4 pclk = ~pclk;
    // log accepted frames and flush pulses
    always @(posedge pclk)
    begin
        if (tx_valid && tx_ready) sent.push_back(tx_frame);
        if (tx_valid && tx_ready) t_sent.push_back(int'($time));
        if (flush_message_buffer) flushes++;
    end
    task automatic chk(input logic [$bits(cctx_frame_s)-1:0] g, e);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [2:0] op, h, input logic [31:0] m, e);
        apb(1'b1, 12'h004, {25'h0, h, 1'b0, op});
        apb(1'b0, 12'h008, 32'h0);
        chk(rd & m, e);
    endtask
    // wait up to c cycles for q frames
    task automatic settle(input int c, q);
        for (int i = 0; i < c && sent.size() < q; i++) @(posedge pclk);
    endtask
    task automatic t_basic();
        for (int i = 0; i < 2; i++)
        begin
            ctl_status <= i ? 8'h1E : 8'hE1;
            message_buffer_full <= i[0];
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, {23'h0, i[0], i ? 8'h1E : 8'hE1});
        end
        apb(1'b0, 12'h100, 32'h0);
        chk({se, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'h01C, 32'h003C0012);
        apb(1'b1, 12'h01C, 32'h01000012);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h3C);
    endtask
    task automatic t_table();
        apb(1'b1, 12'h010, 32'h00050008);
        apb(1'b1, 12'h014, 32'h03020100);
        apb(1'b1, 12'h018, 32'h07060504);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 12'h00C, {1'b0, ~i[0], i[0], 29'h1ABCDE00 + 29'(i)});
            cmd(3'h1, 3'h0, 32'h37, i < 5 ? i : 32'h17);
        end
        cmd(3'h2, 3'h2, 32'h30, 32'h0);
        cmd(3'h1, 3'h0, 32'h37, 32'h2);
        cmd(3'h3, 3'h6, 32'h30, 32'h10);
        cmd(3'h2, 3'h5, 32'h30, 32'h10);
    endtask
    task automatic t_tx();
        sent.delete();
        cmd(3'h3, 3'h0, 32'h30, 32'h0);
        cmd(3'h3, 3'h1, 32'h30, 32'h0);
        settle(200, 2);
        chk(sent[0], f0);
        chk(sent[1], f1);
        slow <= 1'b1;
        settle(200, 4);
        chk(sent[2], f0);
        chk(t_sent[2] - t_sent[0], (5 * 10 + 2) * 8); // five ticks of ten, plus two stall cycles
        cmd(3'h4, 3'h0, 32'h30, 32'h0);
        cmd(3'h4, 3'h1, 32'h30, 32'h0);
        settle(20, 99);
        k = sent.size();
        settle(150, 99);
        chk(sent.size(), k);
        cmd(3'h3, 3'h0, 32'h30, 32'h0);
        settle(150, k + 1);
        chk(sent[k], f0);
        cmd(3'h2, 3'h0, 32'h30, 32'h0);
        settle(20, 99);
        k = sent.size();
        settle(150, 99);
        chk(sent.size(), k);
        apb(1'b0, 12'h02C, 32'h0);
        chk(rd, 32'h1E);
    endtask
    task automatic t_port();
        apb(1'b1, 12'h028, 32'h1);
        apb(1'b1, 12'h030, 32'h2);
        cmd(3'h5, 3'h0, 32'h30, 32'h30);
        apb(1'b1, 12'h030, 32'h1);
        cmd(3'h5, 3'h0, 32'h30, 32'h0);
        chk(flushes, 1);
        chk(irq, 1'b1);
        apb(1'b1, 12'h024, 32'h1F);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
    endtask
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_basic();
        t_table();
        t_tx();
        t_port();
        close_out();
    end
    // hang guard, well beyond the expected run
    initial
    begin
        #300us;
        errors++;
        close_out();
    end
endmodule
